// ### include/dbts_cfg.svh
// Purpose: constants of the dma burst and transfer sizing block
// Assumes: register index equals word address on the plain register port
// Notes:   definitions only
`ifndef DBTS_CFG_SVH
`define DBTS_CFG_SVH
// ==========================================================================
// register offsets
`define DBTS_OFS_BURST_LEN   4'h0
`define DBTS_OFS_BURST_LEFT  4'h1
`define DBTS_OFS_SRC_STEP    4'h2
`define DBTS_OFS_DST_STEP    4'h3
`define DBTS_OFS_XFER_LEN    4'h4
`define DBTS_OFS_XFER_LEFT   4'h5
`define DBTS_OFS_SRC_BSTEP   4'h6
`define DBTS_OFS_DST_BSTEP   4'h7
`define DBTS_OFS_SRC_ADDR    4'h8
`define DBTS_OFS_DST_ADDR    4'h9
// ==========================================================================
// field layout and reset values
`define DBTS_WPB_MSB         4
`define DBTS_WPB_LSB         0
`define DBTS_RST_16          16'h0000
`define DBTS_RST_5           5'h00
`define DBTS_RST_ADDR        32'h0000_0000
`endif

// ### include/dbts_pkg.sv
// Purpose: types of the dma burst and transfer sizing block
// Assumes: nothing
// Notes:   constants live in dbts_cfg.svh
package dbts_pkg;
  typedef logic [3:0]  dbts_addr_t;
  typedef logic [15:0] dbts_word_t;
  typedef logic [31:0] dbts_ptr_t;
  typedef enum logic [1:0] {
    DBTS_IDLE  = 2'b00,
    DBTS_BURST = 2'b01,
    DBTS_GAP   = 2'b11
  } dbts_state_e;
endpackage : dbts_pkg

// ### rtl/dbts_top.sv
// Purpose: burst/transfer sizing and address stepping of one dma channel
// Assumes: word_adv pulses once per moved word while running
// Notes:   registers on a plain port, read data one cycle later
//
// Overview of operation
// - five-bit words-per-burst field, N+1 words
// - burst count shows words left in burst
// - words left stays readable while halted
// - source pointer adds signed word step
// - destination pointer adds signed word step
// - sixteen-bit bursts-per-transfer, N+1 bursts
// - config writes need protected-write unlock
// - sixteen-bit bursts-left counter readable
// - per-burst signed steps after each burst
`timescale 1ns/10ps
`include "dbts_cfg.svh"
module dbts_top
  import dbts_pkg::*;
(
  // clock, reset, enable
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic            clk_en,
  // register port
  input  wire dbts_pkg::dbts_addr_t reg_addr,
  input  wire dbts_pkg::dbts_word_t reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output      dbts_pkg::dbts_word_t reg_rdata,
  // channel control
  input  wire logic            protected_write_unlock,
  input  wire logic            start_xfer,
  input  wire logic            halt,
  input  wire logic            word_adv,
  input  wire dbts_pkg::dbts_ptr_t src_begin,
  input  wire dbts_pkg::dbts_ptr_t dst_begin,
  // status out
  output      dbts_pkg::dbts_ptr_t src_addr,
  output      dbts_pkg::dbts_ptr_t dst_addr,
  output      logic            burst_done,
  output      logic            xfer_done,
  output      logic            busy
);
  import dbts_pkg::*;

  // ==========================================================================
  // registers
  logic [4:0]  words_per_burst_field_reg;
  logic [4:0]  words_left_count_reg;
  dbts_word_t  source_word_step_reg;
  dbts_word_t  dest_word_step_reg;
  dbts_word_t  bursts_per_transfer_reg;
  dbts_word_t  bursts_left_count_reg;
  dbts_word_t  src_per_burst_step_reg;
  dbts_word_t  dst_per_burst_step_reg;
  dbts_ptr_t   src_addr_reg;
  dbts_ptr_t   dst_addr_reg;
  dbts_word_t  rdata_reg;
  logic        burst_done_reg;
  logic        xfer_done_reg;
  logic        busy_reg;
  dbts_state_e state_reg;
  dbts_state_e state_next;

  logic wr_ok;
  logic wr_cnt;
  logic run;
  logic last_word;
  logic last_burst;

  assign wr_ok      = clk_en && reg_wr && protected_write_unlock;
  assign wr_cnt     = clk_en && reg_wr && reg_addr == `DBTS_OFS_BURST_LEFT;
  assign run        = state_reg == DBTS_BURST && !halt;
  assign last_word  = run && word_adv && words_left_count_reg == 5'h01;
  assign last_burst = bursts_left_count_reg == `DBTS_RST_16;

  // ==========================================================================
  // state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DBTS_IDLE:  if (start_xfer) state_next = DBTS_BURST;
      DBTS_BURST: if (last_word) state_next = last_burst ? DBTS_IDLE : DBTS_GAP;
      DBTS_GAP:   if (!halt) state_next = DBTS_BURST;
      default:    state_next = DBTS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) state_reg <= DBTS_IDLE;
    else if (clk_en) state_reg <= state_next;
  end

  // ==========================================================================
  // configuration registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      words_per_burst_field_reg <= `DBTS_RST_5;
      source_word_step_reg      <= `DBTS_RST_16;
      dest_word_step_reg        <= `DBTS_RST_16;
      bursts_per_transfer_reg   <= `DBTS_RST_16;
      src_per_burst_step_reg    <= `DBTS_RST_16;
      dst_per_burst_step_reg    <= `DBTS_RST_16;
    end else if (wr_ok) begin
      unique case (reg_addr)
        `DBTS_OFS_BURST_LEN: words_per_burst_field_reg <= reg_wdata[`DBTS_WPB_MSB:`DBTS_WPB_LSB];
        `DBTS_OFS_SRC_STEP:  source_word_step_reg      <= reg_wdata;
        `DBTS_OFS_DST_STEP:  dest_word_step_reg        <= reg_wdata;
        `DBTS_OFS_XFER_LEN:  bursts_per_transfer_reg   <= reg_wdata;
        `DBTS_OFS_SRC_BSTEP: src_per_burst_step_reg    <= reg_wdata;
        `DBTS_OFS_DST_BSTEP: dst_per_burst_step_reg    <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // words-left counter, frozen on halt
  always_ff @(posedge clk_sys) begin
    if (!rst_n) words_left_count_reg <= `DBTS_RST_5;
    else if (clk_en) begin
      if (state_reg != DBTS_BURST && state_next == DBTS_BURST)
        words_left_count_reg <= 5'(words_per_burst_field_reg + 5'h01);
      else if (run && word_adv)
        words_left_count_reg <= words_left_count_reg - 5'h01;
      else if (wr_cnt)
        words_left_count_reg <= reg_wdata[`DBTS_WPB_MSB:`DBTS_WPB_LSB];
    end
  end

  // ==========================================================================
  // bursts-left counter
  always_ff @(posedge clk_sys) begin
    if (!rst_n) bursts_left_count_reg <= `DBTS_RST_16;
    else if (clk_en) begin
      if (state_reg == DBTS_IDLE && start_xfer)
        bursts_left_count_reg <= bursts_per_transfer_reg;
      else if (last_word && !last_burst)
        bursts_left_count_reg <= bursts_left_count_reg - 16'h0001;
    end
  end

  // ==========================================================================
  // address pointers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      src_addr_reg <= `DBTS_RST_ADDR;
      dst_addr_reg <= `DBTS_RST_ADDR;
    end else if (clk_en) begin
      if (state_reg == DBTS_IDLE && start_xfer) begin
        src_addr_reg <= src_begin;
        dst_addr_reg <= dst_begin;
      end else if (last_word) begin
        src_addr_reg <= src_addr_reg + 32'(signed'(src_per_burst_step_reg));
        dst_addr_reg <= dst_addr_reg + 32'(signed'(dst_per_burst_step_reg));
      end else if (run && word_adv) begin
        src_addr_reg <= src_addr_reg + 32'(signed'(source_word_step_reg));
        dst_addr_reg <= dst_addr_reg + 32'(signed'(dest_word_step_reg));
      end
    end
  end

  // ==========================================================================
  // completion pulses
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      burst_done_reg <= 1'b0;
      xfer_done_reg  <= 1'b0;
      busy_reg       <= 1'b0;
    end else if (clk_en) begin
      burst_done_reg <= last_word;
      xfer_done_reg  <= last_word && last_burst;
      busy_reg       <= state_next != DBTS_IDLE;
    end
  end

  // ==========================================================================
  // read port
  always_ff @(posedge clk_sys) begin
    if (!rst_n) rdata_reg <= `DBTS_RST_16;
    else if (clk_en && reg_rd) begin
      unique case (reg_addr)
        `DBTS_OFS_BURST_LEN:  rdata_reg <= {11'h000, words_per_burst_field_reg};
        `DBTS_OFS_BURST_LEFT: rdata_reg <= {11'h000, words_left_count_reg};
        `DBTS_OFS_SRC_STEP:   rdata_reg <= source_word_step_reg;
        `DBTS_OFS_DST_STEP:   rdata_reg <= dest_word_step_reg;
        `DBTS_OFS_XFER_LEN:   rdata_reg <= bursts_per_transfer_reg;
        `DBTS_OFS_XFER_LEFT:  rdata_reg <= bursts_left_count_reg;
        `DBTS_OFS_SRC_BSTEP:  rdata_reg <= src_per_burst_step_reg;
        `DBTS_OFS_DST_BSTEP:  rdata_reg <= dst_per_burst_step_reg;
        `DBTS_OFS_SRC_ADDR:   rdata_reg <= src_addr_reg[15:0];
        `DBTS_OFS_DST_ADDR:   rdata_reg <= dst_addr_reg[15:0];
        default:              rdata_reg <= `DBTS_RST_16;
      endcase
    end
  end

  assign reg_rdata  = rdata_reg;
  assign src_addr   = src_addr_reg;
  assign dst_addr   = dst_addr_reg;
  assign burst_done = burst_done_reg;
  assign xfer_done  = xfer_done_reg;
  assign busy       = busy_reg;

  // ==========================================================================
  // assertions
  property p_wpb_reserved;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && reg_rd && reg_addr == `DBTS_OFS_BURST_LEN |=> reg_rdata[15:5] == 11'h000;
  endproperty
  a_wpb_reserved: assert property (p_wpb_reserved) else $error("reserved burst bits not zero");

  property p_count_step;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && run && word_adv && !last_word |=> words_left_count_reg == $past(words_left_count_reg) - 5'h01;
  endproperty
  a_count_step: assert property (p_count_step) else $error("words left did not step");

  property p_halt_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && halt && state_reg == DBTS_BURST && !wr_cnt |=> $stable(words_left_count_reg);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("count moved while halted");

  property p_src_step;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && run && word_adv && !last_word
      |=> src_addr_reg == $past(src_addr_reg) + 32'(signed'($past(source_word_step_reg)));
  endproperty
  a_src_step: assert property (p_src_step) else $error("source step wrong");

  property p_dst_step;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && run && word_adv && !last_word
      |=> dst_addr_reg == $past(dst_addr_reg) + 32'(signed'($past(dest_word_step_reg)));
  endproperty
  a_dst_step: assert property (p_dst_step) else $error("destination step wrong");

  property p_xfer_len;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && state_reg == DBTS_IDLE && start_xfer |=> bursts_left_count_reg == $past(bursts_per_transfer_reg);
  endproperty
  a_xfer_len: assert property (p_xfer_len) else $error("bursts left not loaded");

  property p_locked;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && reg_wr && !protected_write_unlock |=> $stable(words_per_burst_field_reg) && $stable(bursts_per_transfer_reg);
  endproperty
  a_locked: assert property (p_locked) else $error("locked write took effect");

  property p_burst_end;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && last_word && !last_burst |=> burst_done && bursts_left_count_reg == $past(bursts_left_count_reg) - 16'h0001;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst end not counted");

  property p_bstep;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && last_word |=> src_addr_reg == $past(src_addr_reg) + 32'(signed'($past(src_per_burst_step_reg)));
  endproperty
  a_bstep: assert property (p_bstep) else $error("burst step wrong");

  property p_load;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && state_reg == DBTS_IDLE && start_xfer |=> words_left_count_reg == 5'($past(words_per_burst_field_reg) + 5'h01);
  endproperty
  a_load: assert property (p_load) else $error("words left not loaded");

  c_burst: cover property (@(posedge clk_sys) disable iff (!rst_n) burst_done);
  c_xfer:  cover property (@(posedge clk_sys) disable iff (!rst_n) xfer_done);
  c_halt:  cover property (@(posedge clk_sys) disable iff (!rst_n) halt && state_reg == DBTS_BURST);
endmodule : dbts_top

// ### sim/dbts_mem_model.sv
// Purpose: far-side memory model, acknowledges one word per pulse
// Assumes: busy and burst_done from the sizing block
// Notes:   slow mode stretches the gap between words
`timescale 1ns/10ps
module dbts_mem_model (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // control from bench
  input  wire logic en,
  input  wire logic slow,
  // dma side
  input  wire logic busy,
  input  wire logic burst_done,
  output      logic word_adv
);
  logic [1:0] cool_reg;
  // ==========================================================
  // word pacing
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      word_adv <= 1'b0;
      cool_reg <= 2'h0;
    end else begin
      // en stays up in halt on purpose: those words must be ignored
      word_adv <= en && busy && (cool_reg == 2'h0) && !burst_done && !word_adv;
      if (burst_done) cool_reg <= 2'h2;
      else if (word_adv && slow) cool_reg <= 2'h3;
      else if (cool_reg != 2'h0) cool_reg <= cool_reg - 2'h1;
    end
  end
endmodule : dbts_mem_model

// ### sim/tb_dma_burst_transfer_sizing.sv
// Purpose: self-checking bench of the burst and transfer sizing block
// Assumes: read data checked one cycle after each read strobe
// Notes:   expected values queued by the driver, popped by monitor
`timescale 1ns/10ps
`include "dbts_cfg.svh"
module tb_dma_burst_transfer_sizing;
  import dbts_pkg::*;
  logic       clk_sys, rst_n, clk_en, reg_wr, reg_rd, rd_d;
  logic       protected_write_unlock, start_xfer, halt, word_adv;
  logic       burst_done, xfer_done, busy, model_en, slow;
  dbts_addr_t reg_addr;
  dbts_word_t reg_wdata, reg_rdata;
  dbts_ptr_t  src_begin, dst_begin, src_addr, dst_addr, sb, db, x;
  dbts_ptr_t  rd_q[$];
  dbts_ptr_t  ptr_q[$];
  int         mismatches, checks_done, bd_cnt;
  dbts_addr_t locked[6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7};
  dbts_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .protected_write_unlock(protected_write_unlock), .start_xfer(start_xfer), .halt(halt),
    .word_adv(word_adv), .src_begin(src_begin), .dst_begin(dst_begin), .src_addr(src_addr),
    .dst_addr(dst_addr), .burst_done(burst_done), .xfer_done(xfer_done), .busy(busy));
  dbts_mem_model mem_u (.clk_sys(clk_sys), .rst_n(rst_n), .en(model_en), .slow(slow),
    .busy(busy), .burst_done(burst_done), .word_adv(word_adv));
  // ==========================================================
  // helpers
  function automatic dbts_ptr_t xs(input dbts_ptr_t v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic chk(input string name, input dbts_ptr_t seen, input dbts_ptr_t exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input dbts_addr_t a, input dbts_word_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input dbts_addr_t a, input dbts_word_t e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back({16'h0000, e});
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // ==========================================================
  // clock, monitor, watchdog
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (rd_d === 1'b1) chk("reg_rdata", {16'h0000, reg_rdata}, rd_q.pop_front());
    if (burst_done === 1'b1) bd_cnt++;
    if (xfer_done === 1'b1) begin
      chk("src_addr", src_addr, ptr_q.pop_front());
      chk("dst_addr", dst_addr, ptr_q.pop_front());
    end
    rd_d <= reg_rd;
  end
  initial begin
    repeat (6000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end
  // ==========================================================
  // main sequence
  initial begin
    {rst_n, clk_en, reg_wr, reg_rd, protected_write_unlock} = '0;
    {start_xfer, halt, model_en, slow, reg_addr, reg_wdata} = '0;
    {src_begin, dst_begin} = '0;
    x = 32'd34;
    clk_en = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) rd(dbts_addr_t'(i), 16'h0000);
    rd(4'hc, 16'h0000);
    foreach (locked[i]) begin
      wr(locked[i], 16'h0005);
      rd(locked[i], 16'h0000);
    end
    x = xs(x);
    wr(`DBTS_OFS_BURST_LEFT, x[15:0]);
    rd(`DBTS_OFS_BURST_LEFT, {11'h000, x[4:0]});
    // write while frozen by the clock enable must be lost
    clk_en <= 1'b0;
    wr(`DBTS_OFS_BURST_LEFT, ~x[15:0]);
    clk_en <= 1'b1;
    rd(`DBTS_OFS_BURST_LEFT, {11'h000, x[4:0]});
    protected_write_unlock <= 1'b1;
    wr(`DBTS_OFS_BURST_LEN, 16'hffe2);
    rd(`DBTS_OFS_BURST_LEN, 16'h0002);
    wr(`DBTS_OFS_XFER_LEN, 16'hffff);
    rd(`DBTS_OFS_XFER_LEN, 16'hffff);
    wr(`DBTS_OFS_XFER_LEN, 16'h0001);
    wr(`DBTS_OFS_SRC_STEP, 16'hffff);
    wr(`DBTS_OFS_DST_STEP, 16'h0002);
    wr(`DBTS_OFS_SRC_BSTEP, 16'h0fff);
    wr(`DBTS_OFS_DST_BSTEP, 16'hf000);
    rd(`DBTS_OFS_SRC_STEP, 16'hffff);
    x = xs(x);
    sb = x;
    x = xs(x);
    db = x;
    ptr_q.push_back(sb + 32'd8186);
    ptr_q.push_back(db - 32'd8184);
    @(posedge clk_sys);
    src_begin <= sb;
    dst_begin <= db;
    start_xfer <= 1'b1;
    @(posedge clk_sys);
    start_xfer <= 1'b0;
    model_en <= 1'b1;
    do @(posedge clk_sys); while (word_adv !== 1'b1);
    chk("busy", {31'h0, busy}, 32'h1);
    halt <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(`DBTS_OFS_BURST_LEFT, 16'h0002);
    rd(`DBTS_OFS_XFER_LEFT, 16'h0001);
    rd(`DBTS_OFS_SRC_ADDR, sb[15:0] - 16'h0001);
    rd(`DBTS_OFS_DST_ADDR, db[15:0] + 16'h0002);
    halt <= 1'b0;
    slow <= 1'b1;
    do @(posedge clk_sys); while (busy !== 1'b0);
    model_en <= 1'b0;
    rd(`DBTS_OFS_XFER_LEFT, 16'h0000);
    repeat (3) @(posedge clk_sys);
    chk("burst_done count", bd_cnt, 32'd2);
    chk("pointer checks left", 32'(ptr_q.size()), 32'h0);
    chk("reads left", 32'(rd_q.size()), 32'h0);
    summarize();
  end
endmodule : tb_dma_burst_transfer_sizing
